/* mcrb_pkg.sv */
// Constants for the metering configuration register bank.
// Assumes 24-bit registers addressed by a 6-bit register index.
package mcrb_pkg;
   // ===================================
   // Sizes
   localparam int DATA_W = 24;
   localparam int ADDR_W = 6;
   // ===================================
   // Register indices
   localparam logic [5:0] IDX_BASE_CFG = 6'h00;
   localparam logic [5:0] IDX_IZX = 6'h18;
   localparam logic [5:0] IDX_PULSE = 6'h1C;
   localparam logic [5:0] IDX_COIL_INTEGRATOR_GAIN = 6'h2B;
   localparam logic [5:0] IDX_V1SW_DUR = 6'h2E;
   localparam logic [5:0] IDX_V1SW_LVL = 6'h2F;
   localparam logic [5:0] IDX_V2SW_DUR = 6'h32;
   localparam logic [5:0] IDX_V2SW_LVL = 6'h33;
   localparam logic [5:0] IDX_VZX = 6'h3A;
   localparam logic [5:0] IDX_CYCLES = 6'h3E;
   localparam logic [5:0] IDX_SCALE = 6'h3F;
   // ===================================
   // Reset values
   localparam logic [23:0] RST_BASE_CFG = 24'h400000;
   localparam logic [23:0] RST_ZX = 24'h100000;
   localparam logic [23:0] RST_PULSE = 24'h800000;
   localparam logic [23:0] RST_COIL_INTEGRATOR_GAIN = 24'h143958;
   localparam logic [23:0] RST_SW_DUR = 24'h000000;
   localparam logic [23:0] RST_SW_LVL = 24'h7FFFFF;
   localparam logic [23:0] RST_CYCLES = 24'h000064;
   localparam logic [23:0] RST_SCALE = 24'h4CCCCC;
   // ===================================
   // Base configuration fields
   localparam int B_TEMP_OR_VOLT2_SELECT = 23;
   localparam int B_ONE = 22;
   localparam int B_CLKINV = 21;
   localparam int B_CLKEN = 20;
   localparam int B_CAP_HI = 14;
   localparam int B_CAP_LO = 13;
   localparam int B_IRQPOL = 8;
   localparam int B_I2G_HI = 7;
   localparam int B_I2G_LO = 6;
   localparam int B_I1G_HI = 5;
   localparam int B_I1G_LO = 4;
   localparam int B_NOOSC = 2;
   localparam int B_IZXCH = 1;
   localparam int B_VZXCH = 0;
   // Writable bits; fixed and reserved bits read back their reset value
   localparam logic [23:0] BASE_WMASK = 24'hB061F7;
   // ===================================
   // Register list order for the bank
   localparam int NREG = 11;
   typedef enum logic [3:0] {
      R_IZX = 4'h0, R_PULSE = 4'h1, R_COIL_INTEGRATOR_GAIN = 4'h2, R_V1SD = 4'h3,
      R_V1SL = 4'h4, R_V2SD = 4'h5, R_V2SL = 4'h6, R_VZX = 4'h7,
      R_SCALE = 4'h8, R_CYCLES = 4'h9, R_BASE = 4'hA
   } mcrb_reg_t;
   // Checksum engine states
   typedef enum logic [1:0] {
      CS_IDLE = 2'b01,
      CS_RUN = 2'b10
   } mcrb_cs_t;
endpackage

/* mcrb_csum.sv */
// Register checksum engine: sums the protected registers one per cycle.
// Assumes the register words stay stable or a restart is requested.
module mcrb_csum
   import mcrb_pkg::*;
#(
   parameter int W = 24,
   parameter int N = 10
)
(
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // Control
   input wire logic start,
   input wire logic [N-1:0] inclMask,
   input wire logic [N*W-1:0] words,
   // Result
   output logic [W-1:0] sum,
   output logic done
);
   // ===================================
   // Sequencer
   mcrb_cs_t state_r, state_nxt;
   logic [4:0] idx_r, idx_nxt;
   logic [W-1:0] acc_r, acc_nxt, sum_r, sum_nxt;
   logic done_r, done_nxt;
   logic [W-1:0] term;

   always_comb
   begin
      term = '0;
      if (idx_r < 5'(N) && inclMask[idx_r[3:0]])
      begin
         term = words[idx_r*W +: W];
      end
   end

   always_comb
   begin
      state_nxt = state_r;
      idx_nxt = idx_r;
      acc_nxt = acc_r;
      sum_nxt = sum_r;
      done_nxt = 1'b0;
      case (state_r)
         CS_IDLE:
         begin
            if (start)
            begin
               state_nxt = CS_RUN;
               idx_nxt = '0;
               acc_nxt = '0;
            end
         end
         CS_RUN:
         begin
            if (start)
            begin
               // A new write restarts the walk so no stale word is summed
               idx_nxt = '0;
               acc_nxt = '0;
            end
            else if (idx_r == 5'(N - 1))
            begin
               sum_nxt = acc_r + term;
               done_nxt = 1'b1;
               state_nxt = CS_IDLE;
            end
            else
            begin
               acc_nxt = acc_r + term;
               idx_nxt = idx_r + 5'd1;
            end
         end
         default:
         begin
            state_nxt = CS_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         state_r <= CS_IDLE;
         idx_r <= '0;
         acc_r <= '0;
         sum_r <= '0;
         done_r <= 1'b0;
      end
      else
      begin
         state_r <= state_nxt;
         idx_r <= idx_nxt;
         acc_r <= acc_nxt;
         sum_r <= sum_nxt;
         done_r <= done_nxt;
      end
   end

   assign sum = sum_r;
   assign done = done_r;
endmodule

/* mcrb_bank.sv */
// Configuration register bank of the metering front end.
// Assumes the serial port front end delivers decoded single-cycle
// register reads and writes; the internal processor has its own port.
module mcrb_bank
   import mcrb_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // Host register port
   input wire logic hostWrite,
   input wire logic hostRead,
   input wire logic [ADDR_W-1:0] hostAddr,
   input wire logic [DATA_W-1:0] hostWdata,
   output logic [DATA_W-1:0] hostRdata,
   output logic hostRvalid,
   // Internal processor write port
   input wire logic procWrite,
   input wire logic [ADDR_W-1:0] procAddr,
   input wire logic [DATA_W-1:0] procWdata,
   // Write protect masks, one bit per bank register
   input wire logic [NREG-1:0] hostProtect,
   input wire logic [NREG-1:0] procProtect,
   // Context from elsewhere in the device
   input wire logic averaging_select,
   input wire logic [DATA_W-1:0] sample_total,
   input wire logic irqRaw,
   input wire logic mclkLevel,
   // Configuration outputs
   output logic temp_or_volt2_select,
   output logic processor_clock_out,
   output logic [1:0] volt2_sample_cap_select,
   output logic irqPin,
   output logic [1:0] current2_amp_gain,
   output logic [1:0] current1_amp_gain,
   output logic crystal_osc_disable,
   output logic current_crossing_channel,
   output logic voltage_crossing_channel,
   output logic [DATA_W-1:0] current_zero_cross_threshold,
   output logic [DATA_W-1:0] voltage_zero_cross_threshold,
   output logic [DATA_W-1:0] energy_pulse_rate,
   output logic [DATA_W-1:0] coil_integrator_gain,
   output logic [DATA_W-1:0] cycleTotal,
   output logic [DATA_W-1:0] calScale,
   // Checksum
   output logic [DATA_W-1:0] regChecksum,
   output logic checksumValid
);
   // ===================================
   // Register array and its decode
   localparam logic [NREG*DATA_W-1:0] RST_ALL = {
      RST_BASE_CFG, RST_CYCLES, RST_SCALE, RST_ZX, RST_SW_LVL,
      RST_SW_DUR, RST_SW_LVL, RST_SW_DUR, RST_COIL_INTEGRATOR_GAIN, RST_PULSE,
      RST_ZX};
   localparam logic [NREG*ADDR_W-1:0] IDX_ALL = {
      IDX_BASE_CFG, IDX_CYCLES, IDX_SCALE, IDX_VZX, IDX_V2SW_LVL,
      IDX_V2SW_DUR, IDX_V1SW_LVL, IDX_V1SW_DUR, IDX_COIL_INTEGRATOR_GAIN, IDX_PULSE,
      IDX_IZX};

   logic [DATA_W-1:0] regs_r [NREG];
   logic [DATA_W-1:0] regs_nxt [NREG];
   logic [NREG-1:0] hostHit, procHit;
   logic [NREG*DATA_W-1:0] flat;
   logic anyWrite;

   genvar g;
   generate
      for (g = 0; g < NREG; g++)
      begin : gReg
         localparam logic [DATA_W-1:0] WM =
            (g == int'(R_BASE)) ? BASE_WMASK : {DATA_W{1'b1}};
         assign hostHit[g] = hostWrite &&
            hostAddr == IDX_ALL[g*ADDR_W +: ADDR_W];
         // The line cycle total has no processor write path at all
         assign procHit[g] = procWrite && g != int'(R_CYCLES) &&
            procAddr == IDX_ALL[g*ADDR_W +: ADDR_W];
         assign flat[g*DATA_W +: DATA_W] = regs_r[g];

         always_comb
         begin
            regs_nxt[g] = regs_r[g];
            // Processor first so a simultaneous host write takes priority
            if (procHit[g] && !procProtect[g])
            begin
               regs_nxt[g] = (regs_r[g] & ~WM) | (procWdata & WM);
            end
            if (hostHit[g] && !hostProtect[g])
            begin
               regs_nxt[g] = (regs_r[g] & ~WM) | (hostWdata & WM);
            end
         end

         always_ff @(posedge clk or negedge reset_n)
         begin
            if (!reset_n)
            begin
               regs_r[g] <= RST_ALL[g*DATA_W +: DATA_W];
            end
            else
            begin
               regs_r[g] <= regs_nxt[g];
            end
         end
      end
   endgenerate

   assign anyWrite = |(hostHit & ~hostProtect) | |(procHit & ~procProtect);

   // ===================================
   // Host read port
   logic [DATA_W-1:0] rdata_nxt, rdata_r;
   logic rvalid_r;

   always_comb
   begin
      rdata_nxt = '0;
      for (int i = 0; i < NREG; i++)
      begin
         if (hostAddr == IDX_ALL[i*ADDR_W +: ADDR_W])
         begin
            rdata_nxt = regs_r[i];
         end
      end
   end

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         rdata_r <= '0;
         rvalid_r <= 1'b0;
      end
      else
      begin
         rdata_r <= hostRead ? rdata_nxt : rdata_r;
         rvalid_r <= hostRead;
      end
   end

   // ===================================
   // Checksum membership
   logic [NREG-2:0] incl;
   logic [(NREG-1)*DATA_W-1:0] csWords;
   logic avgSel_r;

   always_comb
   begin
      incl = '1;
      csWords = flat[(NREG-1)*DATA_W-1:0];
      if (!avgSel_r)
      begin
         csWords[int'(R_CYCLES)*DATA_W +: DATA_W] = sample_total;
      end
   end

   mcrb_csum #(.W(DATA_W), .N(NREG - 1)) uCsum (
      .clk(clk),
      .reset_n(reset_n),
      .start(anyWrite || avgSel_r != averaging_select),
      .inclMask(incl),
      .words(csWords),
      .sum(regChecksum),
      .done(checksumValid)
   );

   // ===================================
   // Configuration decode, all registered
   logic [DATA_W-1:0] base;
   logic [10:0] cfg_nxt, cfg_r;
   logic clkOut_nxt, clkOut_r;

   assign base = regs_r[int'(R_BASE)];

   always_comb
   begin
      cfg_nxt = {
         base[B_TEMP_OR_VOLT2_SELECT],
         base[B_CAP_HI:B_CAP_LO],
         base[B_IRQPOL] ? irqRaw : ~irqRaw,
         base[B_I2G_HI:B_I2G_LO],
         base[B_I1G_HI:B_I1G_LO],
         base[B_NOOSC],
         base[B_IZXCH],
         base[B_VZXCH]};
      // Gated pad: stays low while disabled
      clkOut_nxt = base[B_CLKEN] & (mclkLevel ^ base[B_CLKINV]);
   end

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         // Interrupt pin idles high for the active-low default polarity
         cfg_r <= {1'b0, 2'b00, 1'b1, 2'b00, 2'b00, 3'b000};
         clkOut_r <= 1'b0;
         avgSel_r <= 1'b0;
      end
      else
      begin
         cfg_r <= cfg_nxt;
         clkOut_r <= clkOut_nxt;
         avgSel_r <= averaging_select;
      end
   end

   assign temp_or_volt2_select = cfg_r[10];
   assign volt2_sample_cap_select = cfg_r[9:8];
   assign irqPin = cfg_r[7];
   assign current2_amp_gain = cfg_r[6:5];
   assign current1_amp_gain = cfg_r[4:3];
   assign crystal_osc_disable = cfg_r[2];
   assign current_crossing_channel = cfg_r[1];
   assign voltage_crossing_channel = cfg_r[0];
   assign processor_clock_out = clkOut_r;
   assign current_zero_cross_threshold = regs_r[int'(R_IZX)];
   assign voltage_zero_cross_threshold = regs_r[int'(R_VZX)];
   assign energy_pulse_rate = regs_r[int'(R_PULSE)];
   assign coil_integrator_gain = regs_r[int'(R_COIL_INTEGRATOR_GAIN)];
   assign cycleTotal = regs_r[int'(R_CYCLES)];
   assign calScale = regs_r[int'(R_SCALE)];
   assign hostRdata = rdata_r;
   assign hostRvalid = rvalid_r;
endmodule

/* mcrb_bank_sva.sv */
// Checker for the metering configuration register bank.
// Assumes it sees only the bank's ports, bound below.
module mcrb_bank_sva
   import mcrb_pkg::*;
(
   // Clock and reset
   input logic clk,
   input logic reset_n,
   // Host and processor ports
   input logic hostWrite,
   input logic hostRead,
   input logic [ADDR_W-1:0] hostAddr,
   input logic [DATA_W-1:0] hostWdata,
   input logic [DATA_W-1:0] hostRdata,
   input logic hostRvalid,
   input logic procWrite,
   input logic [ADDR_W-1:0] procAddr,
   input logic [NREG-1:0] hostProtect,
   // Observed registers
   input logic [DATA_W-1:0] current_zero_cross_threshold,
   input logic [DATA_W-1:0] cycleTotal,
   input logic checksumValid
);
   timeunit 1ns;
   timeprecision 1ns;
   // ===================================
   // Assertions
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);
   chk_reset_defaults: assert property ($rose(reset_n) |->
      current_zero_cross_threshold == RST_ZX && cycleTotal == RST_CYCLES)
      else $error("defaults missing after reset");
   chk_read_answer: assert property (hostRead |=> hostRvalid)
      else $error("read not answered");
   chk_no_spur_valid: assert property (!hostRead |=> !hostRvalid)
      else $error("read valid without read");
   chk_izx_write: assert property (hostWrite && hostAddr == IDX_IZX
      && !hostProtect[0] |=> current_zero_cross_threshold == $past(hostWdata))
      else $error("threshold write lost");
   chk_izx_protect: assert property (hostWrite && hostAddr == IDX_IZX
      && hostProtect[0] && !procWrite |=> $stable(current_zero_cross_threshold))
      else $error("protected write landed");
   chk_cycles_proc: assert property (procWrite &&
      procAddr == IDX_CYCLES && !hostWrite |=> $stable(cycleTotal))
      else $error("processor changed cycle total");
   chk_unmapped_read: assert property (hostRead && hostAddr == 6'h19
      |=> hostRdata == 24'h000000)
      else $error("reserved read not zero");
   chk_csum_pulse: assert property (checksumValid |=> !checksumValid)
      else $error("checksum valid longer than a cycle");
   chk_csum_restart: assert property (hostWrite && hostAddr == IDX_IZX
      && !hostProtect[0] |=> !checksumValid [*8])
      else $error("checksum not restarted");
endmodule
bind mcrb_bank mcrb_bank_sva chk_i (.clk, .reset_n, .hostWrite, .hostRead,
   .hostAddr, .hostWdata, .hostRdata, .hostRvalid, .procWrite, .procAddr,
   .hostProtect, .current_zero_cross_threshold, .cycleTotal, .checksumValid);

/* mcrb_host_model.sv */
// Host model: drives single-cycle register requests.
// Assumes requests launch and release on the falling clock edge.
module mcrb_host_model
   import mcrb_pkg::*;
(
   // Clock
   input logic clk,
   // Host request
   output logic hostWrite,
   output logic hostRead,
   output logic [ADDR_W-1:0] hostAddr,
   output logic [DATA_W-1:0] hostWdata
);
   timeunit 1ns;
   timeprecision 1ns;
   initial
   begin
      hostWrite = 1'b0;
      hostRead = 1'b0;
      hostAddr = 6'h00;
      hostWdata = 24'h000000;
   end
   // Reserved addresses only when the bench asks for a refusal case
   task automatic wr(input logic [5:0] a, input logic [23:0] d);
      @(negedge clk);
      hostWrite = 1'b1;
      hostAddr = a;
      // Fixed bits kept; capacitor select never takes a reserved 1x code
      hostWdata = (a == IDX_BASE_CFG) ?
         (d & BASE_WMASK & 24'hFFBFFF) | 24'h400000 : d;
      @(negedge clk);
      hostWrite = 1'b0;
      // Released lines flip so stale values never look valid
      hostAddr = ~a;
      hostWdata = ~hostWdata;
   endtask
   task automatic rd(input logic [5:0] a);
      @(negedge clk);
      hostRead = 1'b1;
      hostAddr = a;
      @(negedge clk);
      hostRead = 1'b0;
      hostAddr = ~a;
   endtask
endmodule

/* mcrb_bank_tb_top.sv */
// Self-checking bench for the metering configuration register bank.
// Assumes the host model, the bank and its bound checker.
module mcrb_bank_tb_top
   import mcrb_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   // ===================================
   // Signals
   logic clk = 0, reset_n = 0, procWrite = 0, averaging_select = 0;
   logic irqRaw = 0, mclkLevel = 0, hostWrite, hostRead, hostRvalid;
   logic [5:0] hostAddr, procAddr = 6'h00;
   logic [23:0] hostWdata, hostRdata, procWdata = 0, sample_total = 0;
   logic [10:0] hostProtect = 0, procProtect = 0;
   logic temp_or_volt2_select, processor_clock_out, irqPin, checksumValid;
   logic crystal_osc_disable, current_crossing_channel;
   logic voltage_crossing_channel;
   logic [1:0] volt2_sample_cap_select, current2_amp_gain, current1_amp_gain;
   logic [23:0] current_zero_cross_threshold, voltage_zero_cross_threshold, energy_pulse_rate, coil_integrator_gain, cycleTotal;
   logic [23:0] calScale, regChecksum, d;
   int n_errors = 0, checked = 0;
   logic [23:0] expQ[$];
   logic [5:0] adr[11] = '{IDX_IZX, IDX_PULSE, IDX_COIL_INTEGRATOR_GAIN, IDX_V1SW_DUR,
      IDX_V1SW_LVL, IDX_V2SW_DUR, IDX_V2SW_LVL, IDX_VZX, IDX_SCALE,
      IDX_CYCLES, IDX_BASE_CFG};
   logic [23:0] sh[11] = '{24'h100000, 24'h800000, 24'h143958, 24'h000000,
      24'h7FFFFF, 24'h000000, 24'h7FFFFF, 24'h100000, 24'h4CCCCC,
      24'h000064, 24'h400000};
   logic [23:0] cfg[2] = '{24'hB02187, 24'h100020};
   // ===================================
   // Instances
   mcrb_host_model host (.clk, .hostWrite, .hostRead, .hostAddr, .hostWdata);
   mcrb_bank uut (.clk, .reset_n, .hostWrite, .hostRead, .hostAddr,
      .hostWdata, .hostRdata, .hostRvalid, .procWrite, .procAddr,
      .procWdata, .hostProtect, .procProtect, .averaging_select,
      .sample_total, .irqRaw, .mclkLevel, .temp_or_volt2_select,
      .processor_clock_out, .volt2_sample_cap_select, .irqPin,
      .current2_amp_gain, .current1_amp_gain, .crystal_osc_disable,
      .current_crossing_channel, .voltage_crossing_channel, .current_zero_cross_threshold,
      .voltage_zero_cross_threshold, .energy_pulse_rate, .coil_integrator_gain, .cycleTotal, .calScale,
      .regChecksum, .checksumValid);
   initial
   begin
      forever #5 clk = ~clk;
   end
   // ===================================
   // Tasks
   task automatic chk(input logic [23:0] seen, exp, input string nm);
      checked++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic wr(input int i, input logic [23:0] v);
      host.wr(adr[i], v);
      if (!hostProtect[i])
         sh[i] = (i == 10) ? (v & BASE_WMASK & 24'hFFBFFF) | 24'h400000 : v;
   endtask
   task automatic rd(input int i);
      expQ.push_back(sh[i]);
      host.rd(adr[i]);
   endtask
   task automatic pw(input int i, input logic [23:0] v);
      @(negedge clk);
      procWrite = 1;
      procAddr = adr[i];
      procWdata = v;
      @(negedge clk);
      procWrite = 0;
      procWdata = ~v;
      // Cycle total never takes processor writes
      if (!procProtect[i] && i != 9)
         sh[i] = v;
   endtask
   task automatic cs();
      logic [23:0] s;
      s = averaging_select ? sh[9] : sample_total;
      for (int i = 0; i < 9; i++)
         s += sh[i];
      // Let a pulse left from the previous sum pass first
      @(negedge clk);
      for (int k = 0; k < 40 && checksumValid !== 1'b1; k++)
         @(negedge clk);
      chk(regChecksum, s, "checksum");
   endtask
   task test_done;
      $display("checked %0d mismatches %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   // ===================================
   // Read monitor
   always @(negedge clk)
      if (hostRvalid === 1'b1)
         chk(hostRdata, expQ.pop_front(), "read data");
   initial
   begin
      #200000;
      n_errors++;
      test_done;
   end
   // ===================================
   // Tests
   initial
   begin
      void'($urandom(32'h58B53DBA));
      repeat (5) @(negedge clk);
      reset_n = 1;
      for (int i = 0; i < 11; i++)
         rd(i);
      chk(calScale, 24'h4CCCCC, "scale out");
      chk(current_zero_cross_threshold, 24'h100000, "izx out");
      chk(voltage_zero_cross_threshold, 24'h100000, "vzx out");
      chk(coil_integrator_gain, 24'h143958, "gain out");
      chk(cycleTotal, 24'h000064, "cycles out");
      chk(energy_pulse_rate, 24'h800000, "pulse out");
      chk(irqPin, 24'h000001, "irq idle");
      chk(processor_clock_out, 24'h000000, "clock idle");
      $display("test defaults done");
      for (int i = 0; i < 11; i++)
      begin
         wr(i, 24'($urandom));
         rd(i);
      end
      averaging_select = 1;
      cs();
      sample_total = 24'($urandom);
      averaging_select = 0;
      cs();
      $display("test readback done");
      hostProtect = 11'h201;
      wr(0, 24'($urandom));
      wr(9, 24'h000010);
      procProtect = 11'h002;
      pw(1, 24'h123456);
      pw(2, 24'h0ABCDE);
      pw(9, 24'h000020);
      hostProtect = 0;
      for (int i = 0; i < 10; i++)
         rd(i);
      chk(energy_pulse_rate, sh[1], "pulse out");
      chk(coil_integrator_gain, sh[2], "gain out");
      chk(cycleTotal, sh[9], "cycles out");
      chk(voltage_zero_cross_threshold, sh[7], "vzx out");
      wr(0, 24'h00ABCD);
      cs();
      $display("test protect done");
      host.wr(6'h19, 24'h555555);
      expQ.push_back(24'h000000);
      host.rd(6'h19);
      $display("test reserved done");
      for (int k = 0; k < 2; k++)
      begin
         wr(10, cfg[k]);
         d = sh[10];
         irqRaw = 1;
         mclkLevel = 1;
         repeat (2) @(negedge clk);
         chk({temp_or_volt2_select, volt2_sample_cap_select,
            current2_amp_gain, current1_amp_gain, crystal_osc_disable,
            current_crossing_channel, voltage_crossing_channel},
            {d[23], d[14:13], d[7:4], d[2:0]}, "config");
         chk(irqPin, d[8], "irq pin");
         chk(processor_clock_out, d[20] & ~d[21], "clock pin");
         rd(10);
      end
      $display("test config done");
      test_done;
   end
endmodule
